//--- src/tpw_pkg.sv
// Purpose: shared constants and types for the two-wire pwm command unit
// Assumes: 40 MHz system clock, serial clock supplied by the bus master
// Notes: command code encodings are defaults for top-level parameters
package tpw_pkg;
	// clock and pwm timing
	localparam int CLK_HZ   = 40_000_000;
	localparam int PWM_HZ   = 25_000;
	localparam int STEPS    = 32;
	localparam int STEP_CYC = CLK_HZ / (PWM_HZ * STEPS);
	// link hold after start, least time in ns, rounded up to cycles
	localparam int HOLD_NS  = 200;
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	// control byte layout
	localparam logic [3:0] CTRL_CODE = 4'h5;
	localparam int CTRL_HI   = 7;
	localparam int CTRL_LO   = 4;
	localparam int SEL_HI    = 3;
	localparam int SEL_LO    = 1;
	localparam int RW_BIT    = 0;
	// data byte layout
	localparam int CODE_HI   = 7;
	localparam int CODE_LO   = 5;
	localparam int DUTY_HI   = 4;
	localparam logic [4:0] DUTY_RST = 5'h10;
	localparam logic [3:0] BIT_ACK  = 4'h8;
	// default command code encodings
	localparam logic [2:0] CODE_DUTY_DEF   = 3'h0;
	localparam logic [2:0] CODE_FULL_DEF   = 3'h1;
	localparam logic [2:0] CODE_SHUT_DEF   = 3'h2;
	localparam logic [2:0] CODE_RECALL_DEF = 3'h3;

	typedef enum logic [1:0] {PH_ADDR, PH_WRITE, PH_READ, PH_IDLE} tpw_phase_e;

	typedef struct packed {
		logic       shut;
		logic       full;
		logic [4:0] duty;
	} tpw_cfg_s;

	typedef struct packed {
		logic [2:0] sel;
		logic [7:0] rd_byte;
	} tpw_pub_s;

	localparam tpw_cfg_s CFG_RST = '{shut: 1'b0, full: 1'b0, duty: DUTY_RST};
endpackage

//--- src/tpw_top.sv
// Purpose: two-wire slave command logic and 5-bit pwm output
// Assumes: scl_in clocks the link logic; sda and straps are external pins
// Notes: start and stop are found in the clk_in domain from synced pins
`timescale 1ns/100ps
module tpw_top #(
	parameter int         STEP_CYC    = tpw_pkg::STEP_CYC,
	parameter logic [2:0] CODE_DUTY   = tpw_pkg::CODE_DUTY_DEF,
	parameter logic [2:0] CODE_FULL   = tpw_pkg::CODE_FULL_DEF,
	parameter logic [2:0] CODE_SHUT   = tpw_pkg::CODE_SHUT_DEF,
	parameter logic [2:0] CODE_RECALL = tpw_pkg::CODE_RECALL_DEF
) (
	// system
	input  wire logic clk_in,
	input  wire logic rst_in,
	// two-wire link
	input  wire logic scl_in,
	input  wire logic sda_in,
	output wire logic sda_out,
	output wire logic sda_oe_n_out,
	// address straps
	input  wire logic select_pin_bit0_in,
	input  wire logic select_pin_bit1_in,
	input  wire logic select_pin_bit2_in,
	// pulse output
	output wire logic pulse_output_out,
	output wire logic pulse_output_oe_n_out
);
	import tpw_pkg::*;

	localparam int PW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
	localparam tpw_pub_s PUB_RST = '{sel: 3'h0, rd_byte: {CODE_DUTY, DUTY_RST}};

	// pin synchronisers, clk_in domain
	logic [1:0] scl_sy_ff;
	logic [1:0] sda_sy_ff;
	logic       scl_prev_ff;
	logic       sda_prev_ff;
	logic [2:0] sel_m_ff;
	logic [2:0] sel_q_ff;
	logic       start_det;
	logic       stop_det;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			scl_sy_ff   <= 2'h3;
			sda_sy_ff   <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
			sel_m_ff    <= 3'h0;
			sel_q_ff    <= 3'h0;
		end
		else
		begin
			scl_sy_ff   <= {scl_sy_ff[0], scl_in};
			sda_sy_ff   <= {sda_sy_ff[0], sda_in};
			scl_prev_ff <= scl_sy_ff[1];
			sda_prev_ff <= sda_sy_ff[1];
			sel_m_ff    <= {select_pin_bit2_in, select_pin_bit1_in, select_pin_bit0_in};
			sel_q_ff    <= sel_m_ff;
		end
	end

	assign start_det = scl_sy_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sy_ff[1];
	assign stop_det  = scl_sy_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sy_ff[1];

	// link logic held in reset while idle and briefly after start
	logic       link_hold_ff;
	logic [3:0] hold_cnt_ff;
	logic       nxt_link_hold;
	logic [3:0] nxt_hold_cnt;
	logic       link_rst;

	assign nxt_hold_cnt  = start_det ? HOLD_CYC :
	                       stop_det ? 4'h0 :
	                       (hold_cnt_ff != 4'h0) ? hold_cnt_ff - 4'h1 : 4'h0;
	assign nxt_link_hold = (start_det | stop_det) ? 1'b1 :
	                       (hold_cnt_ff == 4'h1) ? 1'b0 : link_hold_ff;
	assign link_rst      = rst_in | link_hold_ff;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			link_hold_ff <= 1'b1;
			hold_cnt_ff  <= 4'h0;
		end
		else
		begin
			link_hold_ff <= nxt_link_hold;
			hold_cnt_ff  <= nxt_hold_cnt;
		end
	end

	// link domain, bit and byte sequencing on scl rising edges
	tpw_phase_e ph_ff;
	tpw_phase_e nxt_ph;
	logic [3:0] cnt_ff;
	logic [7:0] shift_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] nxt_shift;
	logic       byte_end;
	logic       addr_hit;
	tpw_pub_s   snap_ff;

	assign byte_end = (cnt_ff == BIT_ACK);
	assign nxt_shift = byte_end ? shift_ff : {shift_ff[6:0], sda_in};
	assign nxt_cnt   = byte_end ? 4'h0 : cnt_ff + 4'h1;
	assign addr_hit  = (shift_ff[CTRL_HI:CTRL_LO] == CTRL_CODE) &&
	                   (shift_ff[SEL_HI:SEL_LO] == snap_ff.sel);

	always_comb
	begin
		nxt_ph = ph_ff;
		if (byte_end)
		begin
			unique case (ph_ff)
				PH_ADDR:  nxt_ph = !addr_hit ? PH_IDLE :
				                   shift_ff[RW_BIT] ? PH_READ : PH_WRITE;
				PH_WRITE: nxt_ph = PH_WRITE;
				PH_READ:  nxt_ph = sda_in ? PH_IDLE : PH_READ;
				PH_IDLE:  nxt_ph = PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge scl_in or posedge link_rst)
	begin
		if (link_rst)
		begin
			ph_ff    <= PH_ADDR;
			cnt_ff   <= 4'h0;
			shift_ff <= 8'h00;
		end
		else
		begin
			ph_ff    <= nxt_ph;
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
		end
	end

	// write byte handed to clk_in domain by toggle, data held stable
	logic [7:0] wr_data_ff;
	logic       wr_tgl_ff;
	logic [2:0] pub_sy_ff;
	tpw_pub_s   pub_ff;
	logic       pub_tgl_ff;
	logic       wr_post;

	assign wr_post = byte_end && (ph_ff == PH_WRITE);

	always_ff @(posedge scl_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_data_ff <= 8'h00;
			wr_tgl_ff  <= 1'b0;
			pub_sy_ff  <= 3'h0;
			snap_ff    <= PUB_RST;
		end
		else
		begin
			wr_data_ff <= wr_post ? shift_ff : wr_data_ff;
			wr_tgl_ff  <= wr_tgl_ff ^ wr_post;
			pub_sy_ff  <= {pub_sy_ff[1:0], pub_tgl_ff};
			snap_ff    <= (pub_sy_ff[2] ^ pub_sy_ff[1]) ? pub_ff : snap_ff;
		end
	end

	// sda drive on scl falling edges
	logic drive_ff;
	logic nxt_drive;

	assign nxt_drive = byte_end ? ((ph_ff == PH_ADDR && addr_hit) || ph_ff == PH_WRITE) :
	                   (ph_ff == PH_READ && !snap_ff.rd_byte[~cnt_ff[2:0]]);

	always_ff @(negedge scl_in or posedge link_rst)
	begin
		if (link_rst)
			drive_ff <= 1'b0;
		else
			drive_ff <= nxt_drive;
	end

	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~drive_ff;

	// configuration register, clk_in domain
	logic [2:0] wr_sy_ff;
	logic       wr_evt;
	logic [2:0] wr_code;
	tpw_cfg_s   cfg_ff;
	tpw_cfg_s   nxt_cfg;
	tpw_pub_s   nxt_pub;
	logic [2:0] st_code;

	assign wr_evt  = wr_sy_ff[2] ^ wr_sy_ff[1];
	assign wr_code = wr_data_ff[CODE_HI:CODE_LO];

	always_comb
	begin
		nxt_cfg = cfg_ff;
		if (wr_evt)
		begin
			if (wr_code == CODE_SHUT)
				nxt_cfg.shut = 1'b1;
			else if (wr_code == CODE_RECALL)
				nxt_cfg.shut = 1'b0;
			else
			begin
				nxt_cfg.duty = wr_data_ff[DUTY_HI:0];
				nxt_cfg.full = (wr_code == CODE_FULL);
			end
		end
	end

	assign st_code = cfg_ff.shut ? CODE_SHUT : cfg_ff.full ? CODE_FULL : CODE_DUTY;
	assign nxt_pub = '{sel: sel_q_ff, rd_byte: {st_code, cfg_ff.duty}};

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_sy_ff   <= 3'h0;
			cfg_ff     <= CFG_RST;
			pub_ff     <= PUB_RST;
			pub_tgl_ff <= 1'b0;
		end
		else
		begin
			wr_sy_ff   <= {wr_sy_ff[1:0], wr_tgl_ff};
			cfg_ff     <= nxt_cfg;
			pub_ff     <= nxt_pub;
			pub_tgl_ff <= pub_tgl_ff ^ (nxt_pub != pub_ff);
		end
	end

	// pwm generator
	logic [PW-1:0] pre_ff;
	logic [4:0]    step_ff;
	logic [4:0]    duty_act_ff;
	logic          full_act_ff;
	logic          out_ff;
	logic          oe_n_ff;
	logic          step_end;
	logic          per_end;

	assign step_end = (pre_ff == PW'(STEP_CYC - 1));
	assign per_end  = step_end && (step_ff == 5'h1f);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pre_ff      <= '0;
			step_ff     <= 5'h00;
			duty_act_ff <= DUTY_RST;
			full_act_ff <= 1'b0;
			out_ff      <= 1'b0;
			oe_n_ff     <= 1'b0;
		end
		else
		begin
			pre_ff      <= step_end ? '0 : pre_ff + PW'(1);
			step_ff     <= step_ff + 5'(step_end);
			duty_act_ff <= per_end ? cfg_ff.duty : duty_act_ff;
			full_act_ff <= per_end ? cfg_ff.full : full_act_ff;
			out_ff      <= full_act_ff | (step_ff < duty_act_ff);
			oe_n_ff     <= cfg_ff.shut;
		end
	end

	assign pulse_output_out      = out_ff;
	assign pulse_output_oe_n_out = oe_n_ff;

	// checks
	logic seen_wr_ff;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			seen_wr_ff <= 1'b0;
		else
			seen_wr_ff <= seen_wr_ff | wr_evt;
	end

	power_up_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!seen_wr_ff |-> cfg_ff.duty == DUTY_RST && !cfg_ff.shut && !cfg_ff.full)
		else $error("power-up setting lost");

	duty_field_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_evt && wr_code != CODE_SHUT && wr_code != CODE_RECALL
		|=> cfg_ff.duty == $past(wr_data_ff[DUTY_HI:0]))
		else $error("duty field not taken");

	shut_hiz_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_evt && wr_code == CODE_SHUT |=> ##1 pulse_output_oe_n_out)
		else $error("shutdown left output driven");

	recall_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_evt && wr_code == CODE_RECALL
		|=> !cfg_ff.shut && $stable(cfg_ff.duty) ##1 !pulse_output_oe_n_out)
		else $error("recall did not restore output");

	full_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
		full_act_ff |=> pulse_output_out)
		else $error("full-on output low");

	duty_cmp_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!full_act_ff |=> pulse_output_out == ($past(step_ff) < $past(duty_act_ff)))
		else $error("pulse output disagrees with duty");

	period_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
		per_end |=> duty_act_ff == $past(cfg_ff.duty) && step_ff == 5'h00)
		else $error("duty not latched at period end");

	addr_ack_a: assert property (@(posedge scl_in) disable iff (link_rst)
		byte_end && ph_ff == PH_ADDR |-> sda_oe_n_out == !addr_hit)
		else $error("control byte ack wrong");

	write_ack_a: assert property (@(posedge scl_in) disable iff (link_rst)
		byte_end && ph_ff == PH_WRITE |-> !sda_oe_n_out)
		else $error("data byte not acknowledged");

	read_bit_a: assert property (@(posedge scl_in) disable iff (link_rst)
		ph_ff == PH_READ && !byte_end |-> sda_oe_n_out == snap_ff.rd_byte[~cnt_ff[2:0]])
		else $error("read bit order wrong");

	idle_quiet_a: assert property (@(posedge scl_in) disable iff (link_rst)
		ph_ff == PH_IDLE |-> sda_oe_n_out)
		else $error("unselected device drove sda");

	write_cov: cover property (@(posedge clk_in) disable iff (rst_in) wr_evt);
	shut_cov: cover property (@(posedge clk_in) disable iff (rst_in)
		wr_evt && wr_code == CODE_SHUT);
	full_cov: cover property (@(posedge clk_in) disable iff (rst_in) full_act_ff);
	read_cov: cover property (@(posedge scl_in) disable iff (link_rst)
		ph_ff == PH_READ && byte_end);
endmodule

//--- tb/tpw_master.sv
// Purpose: behavioural two-wire bus master for the pwm command unit
// Assumes: open-drain lines with pull-up, clock period 125 ns
// Notes: clock stands high between frames
`timescale 1ns/100ps
module tpw_master (
	// bus lines
	output logic      scl_out,
	output logic      sda_rel_out,
	input  wire logic sda_in
);
	initial
	begin
		scl_out = 1'b1;
		sda_rel_out = 1'b1;
	end
	// one clock pulse, data set in low half
	task automatic pulse(input logic b, output logic s);
		#10 sda_rel_out = b;
		#52.5 scl_out = 1'b1;
		#31 s = sda_in;
		#31.5 scl_out = 1'b0;
	endtask
	task automatic start();
		sda_rel_out = 1'b1;
		#300 sda_rel_out = 1'b0;
		#600 scl_out = 1'b0;
	endtask
	task automatic stop();
		#10 sda_rel_out = 1'b0;
		#52.5 scl_out = 1'b1;
		#300 sda_rel_out = 1'b1;
		#1300;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(d[i], s);
		pulse(1'b1, s);
		ack = (s === 1'b0);
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			pulse(1'b1, s);
			d[i] = s;
		end
		pulse(last, s);
	endtask
endmodule

//--- tb/test_two_wire_pwm_command_unit.sv
// Purpose: self-checking bench for the pwm command unit
// Assumes: short pwm step of 2 cycles, default code encodings
// Notes: model state tracks shutdown, full-on and duty
`timescale 1ns/100ps
module test_two_wire_pwm_command_unit;
	import tpw_pkg::*;
	localparam int SC  = 2;
	localparam int PER = STEPS * SC;
	logic       clk_in, rst_in;
	logic [2:0] sel;
	wire logic  scl, sda_rel, sda_w, sda_o, sda_oe_n, pwm, pwm_oe_n;
	int         n_fail, n_tests, k, r;
	logic       shut_m, full_m;
	logic [4:0] duty_m;
	logic [7:0] d;

	tpw_top #(.STEP_CYC(SC), .CODE_DUTY(CODE_DUTY_DEF), .CODE_FULL(CODE_FULL_DEF),
		.CODE_SHUT(CODE_SHUT_DEF), .CODE_RECALL(CODE_RECALL_DEF)) i_dut (
		.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .select_pin_bit0_in(sel[0]),
		.select_pin_bit1_in(sel[1]), .select_pin_bit2_in(sel[2]),
		.pulse_output_out(pwm), .pulse_output_oe_n_out(pwm_oe_n));
	tpw_master i_master (.scl_out(scl), .sda_rel_out(sda_rel), .sda_in(sda_w));
	assign sda_w = sda_rel & (sda_oe_n | sda_o);

	initial clk_in = 1'b0;
	always #12.5 clk_in = ~clk_in;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [7:0] exp_rd();
		return {shut_m ? CODE_SHUT_DEF : (full_m ? CODE_FULL_DEF : CODE_DUTY_DEF), duty_m};
	endfunction
	function automatic void apply(input logic [7:0] v);
		if (v[7:5] == CODE_SHUT_DEF)
			shut_m = 1'b1;
		else if (v[7:5] == CODE_RECALL_DEF)
			shut_m = 1'b0;
		else
		begin
			duty_m = v[4:0];
			full_m = (v[7:5] == CODE_FULL_DEF);
		end
	endfunction
	task automatic frame(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
		input int n, input logic ok);
		logic a;
		i_master.start();
		i_master.wr_byte(c, a);
		check({7'h0, a}, {7'h0, ok});
		for (int i = 0; i < n; i++)
		begin
			i_master.wr_byte((i == n - 1) ? d1 : d0, a);
			check({7'h0, a}, {7'h0, ok});
			if (ok)
				apply((i == n - 1) ? d1 : d0);
		end
		i_master.stop();
	endtask
	task automatic rd_check(input int n);
		logic       a;
		logic [7:0] v;
		i_master.start();
		i_master.wr_byte({CTRL_CODE, sel, 1'b1}, a);
		check({7'h0, a}, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			i_master.rd_byte(i == n - 1, v);
			check(v, exp_rd());
		end
		i_master.stop();
	endtask
	task automatic pwm_check();
		int hi;
		hi = 0;
		repeat (2 * PER + 12) @(negedge clk_in);
		repeat (PER)
		begin
			@(negedge clk_in);
			hi += (pwm === 1'b1);
		end
		check({7'h0, pwm_oe_n}, {7'h0, shut_m});
		if (!shut_m)
			check(8'(hi), 8'(full_m ? PER : duty_m * SC));
	endtask

	initial
	begin
		rst_in = 1'b1;
		sel = 3'h0;
		n_fail = 0;
		n_tests = 0;
		shut_m = 1'b0;
		full_m = 1'b0;
		duty_m = DUTY_RST;
		r = $urandom(69508);
		@(negedge clk_in) sel = 3'($urandom());
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (6) @(negedge clk_in);
		rd_check(1);
		pwm_check();
		$display("test reset done");
		frame({CTRL_CODE, sel ^ 3'h1, 1'b0}, 8'h1f, 8'h00, 1, 1'b0);
		frame({4'ha, sel, 1'b0}, 8'h03, 8'h00, 1, 1'b0);
		rd_check(1);
		$display("test address done");
		for (k = 0; k < 22; k++)
		begin
			case (k)
				0: d = {CODE_DUTY_DEF, 5'h00};
				1: d = {CODE_DUTY_DEF, 5'h1f};
				2: d = {CODE_FULL_DEF, 5'h07};
				3: d = {CODE_SHUT_DEF, 5'h00};
				4: d = {CODE_DUTY_DEF, 5'h05};
				5: d = {CODE_RECALL_DEF, 5'h00};
				default: d = 8'($urandom());
			endcase
			frame({CTRL_CODE, sel, 1'b0}, 8'($urandom()), d, 1 + (k % 3 == 2), 1'b1);
			rd_check(1 + k % 2);
			pwm_check();
		end
		$display("test writes done");
		finish_test();
	end

	initial
	begin
		#2_000_000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
endmodule
